// file: design/i2c_ctrl_controller.sv
`timescale 1ns/10ps
module i2c_ctrl_controller #(
   parameter int QUARTER_CYC = i2c_ctrl_pkg::SCL_FAST_QUARTER_CYC
) (
   i2c_link_if.controller bus,
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic cmd_valid_in,
   input wire i2c_ctrl_pkg::cmd_e cmd_op_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic cmd_ack_in,
   output logic cmd_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out,
   output logic rsp_ack_out
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_START = 4'h2,
      ST_BIT = 4'h4,
      ST_STOP = 4'h8
   } ctl_state_e;

   ctl_state_e state_reg;
   logic [15:0] div_reg;
   logic [1:0] q_reg;
   logic [3:0] nbit_reg;
   logic [8:0] tx_reg;
   logic [8:0] rx_reg;
   logic sda_s1_reg;
   logic sda_s2_reg;
   logic tick;
   logic sda_drive_low;

   assign tick = div_reg == 16'(QUARTER_CYC - 1);
   assign cmd_ready_out = state_reg == ST_IDLE;

   // two-flop synchroniser on the shared data wire
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
      end else begin
         sda_s1_reg <= bus.sda;
         sda_s2_reg <= sda_s1_reg;
      end
   end

   // quarter-period divider, held while idle so phases start aligned
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_reg <= 16'h0000;
      end else if (state_reg == ST_IDLE || tick) begin
         div_reg <= 16'h0000;
      end else begin
         div_reg <= div_reg + 16'h0001;
      end
   end

   // command sequencing; a byte slot is 8 data bits plus the ack bit
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= ST_IDLE;
         q_reg <= 2'h0;
         nbit_reg <= 4'h0;
         tx_reg <= 9'h1ff;
         rx_reg <= 9'h000;
         rsp_valid_out <= 1'b0;
         rsp_data_out <= 8'h00;
         rsp_ack_out <= 1'b0;
      end else begin
         rsp_valid_out <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               q_reg <= 2'h0;
               nbit_reg <= 4'h0;
               if (cmd_valid_in) begin
                  case (cmd_op_in)
                     i2c_ctrl_pkg::CMD_START: state_reg <= ST_START;
                     i2c_ctrl_pkg::CMD_STOP: state_reg <= ST_STOP;
                     i2c_ctrl_pkg::CMD_WRITE: begin
                        tx_reg <= {cmd_data_in, 1'b1};
                        state_reg <= ST_BIT;
                     end
                     default: begin
                        tx_reg <= {8'hff, !cmd_ack_in};
                        state_reg <= ST_BIT;
                     end
                  endcase
               end
            end
            ST_BIT: begin
               if (tick) begin
                  q_reg <= q_reg + 2'h1;
                  if (q_reg == 2'h2) begin
                     rx_reg <= {rx_reg[7:0], sda_s2_reg};
                  end
                  if (q_reg == 2'h3) begin
                     tx_reg <= {tx_reg[7:0], 1'b1};
                     nbit_reg <= nbit_reg + 4'h1;
                     if (nbit_reg == 4'(i2c_ctrl_pkg::BITS_PER_SLOT - 1)) begin
                        state_reg <= ST_IDLE;
                        rsp_valid_out <= 1'b1;
                        rsp_data_out <= rx_reg[8:1];
                        rsp_ack_out <= !rx_reg[0];
                     end
                  end
               end
            end
            default: begin
               if (tick) begin
                  q_reg <= q_reg + 2'h1;
                  if (q_reg == 2'h3) begin
                     state_reg <= ST_IDLE;
                     rsp_valid_out <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // start pulls sda in the high half, stop releases it there
   always_comb begin
      case (state_reg)
         ST_START: sda_drive_low = q_reg[1];
         ST_STOP: sda_drive_low = !q_reg[1];
         ST_BIT: sda_drive_low = !tx_reg[8];
         default: sda_drive_low = 1'b0;
      endcase
   end

   // scl high in quarters 1 and 2; quarter 0 of start or stop keeps
   // the level, so a start from idle gives no short low pulse and a
   // stop leaves scl high for the idle bus
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bus.scl <= 1'b1;
         bus.ctl_sda_oe <= 1'b0;
      end else begin
         bus.ctl_sda_oe <= sda_drive_low;
         case (state_reg)
            ST_BIT: bus.scl <= q_reg == 2'h1 || q_reg == 2'h2;
            ST_START: begin
               if (q_reg != 2'h0) begin
                  bus.scl <= q_reg == 2'h1 || q_reg == 2'h2;
               end
            end
            ST_STOP: begin
               if (q_reg != 2'h0) begin
                  bus.scl <= 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign bus.ctl_sda_o = 1'b0;
endmodule

// file: design/i2c_ctrl_pkg.sv
package i2c_ctrl_pkg;
   // target address: five fixed upper bits, two strapped lower bits
   localparam logic [4:0] ADDR_HIGH = 5'h13;
   // register offsets on every page / on page zero
   localparam logic [7:0] REG_PAGE_SELECT = 8'h00;
   localparam logic [7:0] REG_XOR_CHECKSUM = 8'h7d;
   localparam logic [7:0] REG_CRC_CHECKSUM = 8'h7e;
   localparam logic [7:0] REG_BOOK_SELECT = 8'h7f;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [7:0] BOOK_XOR = 8'h8c;
   localparam logic [7:0] CRC_POLY = 8'h07;
   // values after reset
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] BOOK_RESET = 8'h00;
   localparam logic [7:0] CRC_RESET = 8'h00;
   localparam logic [7:0] XOR_RESET = 8'h00;
   // controller timing: quarter of an scl period at 200 mhz
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SCL_FAST_QUARTER_PS = 625000;
   localparam int SCL_STD_QUARTER_PS = 2500000;
   localparam int SCL_FAST_QUARTER_CYC = SCL_FAST_QUARTER_PS / CLK_PERIOD_PS;
   localparam int SCL_STD_QUARTER_CYC = SCL_STD_QUARTER_PS / CLK_PERIOD_PS;
   localparam int BITS_PER_BYTE = 8;
   localparam int BITS_PER_SLOT = 9;
   // controller commands
   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_STOP = 2'h1,
      CMD_WRITE = 2'h2,
      CMD_READ = 2'h3
   } cmd_e;
endpackage

// file: design/i2c_ctrl_target.sv
// Summary of operation
// R1: i2c target, single and multi-byte transfers
// R2: register zero of each page selects page
// R3: address 10011 plus two strapped bits
// R4: single write acked at address, register, data
// R5: multi-byte write acks and increments address
// R6: read returns byte after repeated start
// R7: controller acks all but last read byte
// R8: page zero register 7f selects book
// R9: controller goes to page zero before book change
// R10: controller writes biquad_filter sets whole, ascending
// R11: two checksums, reads leave them unchanged
// R12: crc poly 07 skips book/page writes
// R13: crc at 7e of page zero, writable
// R14: xor checksum folds each written byte
// R15: xor counts book 8c, not page zero
// R16: xor at 7d page zero book 8c
// R17: writing checksum location loads a value
// R18: foreign address not acked, rest ignored
`timescale 1ns/10ps
module i2c_ctrl_target (
   i2c_link_if.target bus,
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [1:0] adr_sel_in,
   output logic wr_valid_out,
   output logic [7:0] wr_addr_out,
   output logic [7:0] wr_data_out,
   output logic [7:0] wr_page_out,
   output logic [7:0] wr_book_out
);
   typedef enum logic [8:0] {
      ST_ADDR = 9'h001,
      ST_ADDR_ACK = 9'h002,
      ST_REG = 9'h004,
      ST_REG_ACK = 9'h008,
      ST_WDATA = 9'h010,
      ST_WDATA_ACK = 9'h020,
      ST_RDATA = 9'h040,
      ST_RDATA_ACK = 9'h080,
      ST_IGNORE = 9'h100
   } tgt_state_e;

   tgt_state_e state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic [7:0] page_reg;
   logic [7:0] book_reg;
   logic [7:0] crc_reg;
   logic [7:0] xor_reg;
   logic [7:0] mem [0:255];
   logic start_tgl_reg;
   logic start_seen_reg;
   logic [1:0] adr_sync1_reg;
   logic [1:0] adr_sync2_reg;
   logic sda_oe_reg;
   logic [7:0] rx_byte;
   logic [7:0] rd_data;
   logic [7:0] rd_next;
   logic new_frame;
   logic last_bit;
   logic wr_tgl_reg;
   logic [7:0] hold_addr_reg;
   logic [7:0] hold_data_reg;
   logic [7:0] hold_page_reg;
   logic [7:0] hold_book_reg;
   logic [2:0] wr_sync_reg;
   logic [7:0] hold_addr_next;

   // crc-8, msb first, one byte per call
   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < i2c_ctrl_pkg::BITS_PER_BYTE; i++) begin
         r = r[7] ? ((r << 1) ^ i2c_ctrl_pkg::CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // start: sda falls while scl high; the scl rise after it comes a
   // full setup time later, so the toggle is settled when compared
   always_ff @(negedge bus.sda or negedge arst_n_in) begin
      if (!arst_n_in) begin
         start_tgl_reg <= 1'b0;
      end else if (bus.scl) begin
         start_tgl_reg <= ~start_tgl_reg;
      end
   end

   assign new_frame = start_tgl_reg != start_seen_reg;
   assign rx_byte = {shift_reg[6:0], bus.sda};
   assign last_bit = bit_cnt_reg == 3'h7;

   // strap pin synchroniser into the link domain
   always_ff @(posedge bus.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         adr_sync1_reg <= 2'h0;
         adr_sync2_reg <= 2'h0;
      end else begin
         adr_sync1_reg <= adr_sel_in;
         adr_sync2_reg <= adr_sync1_reg;
      end
   end

   // read mux: page on every page, book on page zero, checksums, else storage
   always_comb begin
      rd_data = mem[ptr_reg];
      rd_next = mem[ptr_reg + 8'h01];
      if (ptr_reg == i2c_ctrl_pkg::REG_PAGE_SELECT) begin
         rd_data = page_reg; // R2
      end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                   ptr_reg == i2c_ctrl_pkg::REG_BOOK_SELECT) begin
         rd_data = book_reg; // R8
      end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                   ptr_reg == i2c_ctrl_pkg::REG_CRC_CHECKSUM) begin
         rd_data = crc_reg; // R13
      end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                   book_reg == i2c_ctrl_pkg::BOOK_XOR &&
                   ptr_reg == i2c_ctrl_pkg::REG_XOR_CHECKSUM) begin
         rd_data = xor_reg; // R16
      end
      if (ptr_reg + 8'h01 == i2c_ctrl_pkg::REG_PAGE_SELECT) begin
         rd_next = page_reg;
      end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                   ptr_reg + 8'h01 == i2c_ctrl_pkg::REG_BOOK_SELECT) begin
         rd_next = book_reg;
      end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                   ptr_reg + 8'h01 == i2c_ctrl_pkg::REG_CRC_CHECKSUM) begin
         rd_next = crc_reg;
      end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                   book_reg == i2c_ctrl_pkg::BOOK_XOR &&
                   ptr_reg + 8'h01 == i2c_ctrl_pkg::REG_XOR_CHECKSUM) begin
         rd_next = xor_reg;
      end
   end

   // protocol sequencing, sampled on scl rise
   always_ff @(posedge bus.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= ST_IGNORE;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         start_seen_reg <= 1'b0;
      end else if (new_frame) begin
         // any start, repeated or not, restarts address capture
         start_seen_reg <= start_tgl_reg;
         shift_reg <= {7'h00, bus.sda};
         bit_cnt_reg <= 3'h1;
         state_reg <= ST_ADDR; // R1
      end else begin
         case (state_reg)
            ST_ADDR: begin
               shift_reg <= rx_byte;
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (last_bit) begin
                  if (shift_reg[6:0] ==
                      {i2c_ctrl_pkg::ADDR_HIGH, adr_sync2_reg}) begin // R3
                     state_reg <= ST_ADDR_ACK;
                     tx_reg <= {7'h00, bus.sda}; // direction kept here
                  end else begin
                     state_reg <= ST_IGNORE; // R18
                  end
               end
            end
            ST_ADDR_ACK: begin
               bit_cnt_reg <= 3'h0;
               if (tx_reg[0]) begin
                  state_reg <= ST_RDATA; // R6
                  tx_reg <= rd_data;
               end else begin
                  state_reg <= ST_REG; // R4
               end
            end
            ST_REG: begin
               shift_reg <= rx_byte;
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (last_bit) begin
                  ptr_reg <= rx_byte;
                  state_reg <= ST_REG_ACK;
               end
            end
            ST_REG_ACK: begin
               bit_cnt_reg <= 3'h0;
               state_reg <= ST_WDATA;
            end
            ST_WDATA: begin
               shift_reg <= rx_byte;
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (last_bit) begin
                  state_reg <= ST_WDATA_ACK; // R5
               end
            end
            ST_WDATA_ACK: begin
               ptr_reg <= ptr_reg + 8'h01; // R5
               bit_cnt_reg <= 3'h0;
               state_reg <= ST_WDATA;
            end
            ST_RDATA: begin
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (last_bit) begin
                  state_reg <= ST_RDATA_ACK;
               end
            end
            ST_RDATA_ACK: begin
               bit_cnt_reg <= 3'h0;
               if (!bus.sda) begin
                  ptr_reg <= ptr_reg + 8'h01; // R7
                  tx_reg <= rd_next;
                  state_reg <= ST_RDATA;
               end else begin
                  state_reg <= ST_IGNORE; // R7
               end
            end
            default: begin
               state_reg <= ST_IGNORE;
            end
         endcase
      end
   end

   // register effects of a completed data byte
   always_ff @(posedge bus.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         page_reg <= i2c_ctrl_pkg::PAGE_RESET;
         book_reg <= i2c_ctrl_pkg::BOOK_RESET;
         crc_reg <= i2c_ctrl_pkg::CRC_RESET;
         xor_reg <= i2c_ctrl_pkg::XOR_RESET;
      end else if (!new_frame && state_reg == ST_WDATA && last_bit) begin
         if (ptr_reg == i2c_ctrl_pkg::REG_PAGE_SELECT) begin
            page_reg <= rx_byte; // R2
         end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                      ptr_reg == i2c_ctrl_pkg::REG_BOOK_SELECT) begin
            book_reg <= rx_byte; // R8
         end else if (page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                      ptr_reg == i2c_ctrl_pkg::REG_CRC_CHECKSUM) begin
            crc_reg <= rx_byte; // R13 R17
         end else begin
            crc_reg <= crc8(crc_reg, rx_byte); // R11 R12
            if (book_reg == i2c_ctrl_pkg::BOOK_XOR &&
                page_reg == i2c_ctrl_pkg::PAGE_ZERO &&
                ptr_reg == i2c_ctrl_pkg::REG_XOR_CHECKSUM) begin
               xor_reg <= rx_byte; // R16 R17
            end else if (book_reg == i2c_ctrl_pkg::BOOK_XOR &&
                         page_reg != i2c_ctrl_pkg::PAGE_ZERO) begin
               xor_reg <= xor_reg ^ rx_byte; // R14 R15
            end
         end
      end
   end

   // plain storage; shared by all pages and books to keep area small
   always_ff @(posedge bus.scl) begin
      if (!new_frame && state_reg == ST_WDATA && last_bit) begin
         mem[ptr_reg] <= rx_byte; // R11
      end
   end

   // drive sda on scl fall: acks low, read bits msb first
   always_ff @(negedge bus.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sda_oe_reg <= 1'b0;
      end else begin
         sda_oe_reg <= state_reg == ST_ADDR_ACK || // R4
                       state_reg == ST_REG_ACK ||
                       state_reg == ST_WDATA_ACK || // R5
                       (state_reg == ST_RDATA &&
                        !tx_reg[3'h7 - bit_cnt_reg]); // R6
      end
   end

   assign bus.tgt_sda_o = 1'b0;
   assign bus.tgt_sda_oe = sda_oe_reg;

   // hold the written byte for the system side; next write is 9 scl
   // periods away, so held words are stable when the toggle lands
   always_ff @(posedge bus.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_tgl_reg <= 1'b0;
         hold_addr_reg <= 8'h00;
         hold_data_reg <= 8'h00;
         hold_page_reg <= 8'h00;
         hold_book_reg <= 8'h00;
      end else if (!new_frame && state_reg == ST_WDATA && last_bit) begin
         wr_tgl_reg <= ~wr_tgl_reg;
         hold_addr_reg <= ptr_reg;
         hold_data_reg <= rx_byte;
         hold_page_reg <= page_reg;
         hold_book_reg <= book_reg;
      end
   end

   assign hold_addr_next = hold_addr_reg;

   // toggle crossing into clk_in, third stage for the edge
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_sync_reg <= 3'h0;
      end else begin
         wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
      end
   end

   // capture held words once the event has crossed
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_valid_out <= 1'b0;
         wr_addr_out <= 8'h00;
         wr_data_out <= 8'h00;
         wr_page_out <= 8'h00;
         wr_book_out <= 8'h00;
      end else begin
         wr_valid_out <= wr_sync_reg[2] != wr_sync_reg[1];
         if (wr_sync_reg[2] != wr_sync_reg[1]) begin
            wr_addr_out <= hold_addr_next;
            wr_data_out <= hold_data_reg;
            wr_page_out <= hold_page_reg;
            wr_book_out <= hold_book_reg;
         end
      end
   end
endmodule

// file: design/i2c_link_if.sv
`timescale 1ns/10ps
interface i2c_link_if;
   logic scl;
   logic ctl_sda_o;
   logic ctl_sda_oe;
   logic tgt_sda_o;
   logic tgt_sda_oe;
   logic sda;

   // open-drain wired-and with pull-up
   assign sda = (ctl_sda_oe ? ctl_sda_o : 1'b1) & (tgt_sda_oe ? tgt_sda_o : 1'b1);

   modport target (
      input scl,
      input sda,
      output tgt_sda_o,
      output tgt_sda_oe
   );
   modport controller (
      output scl,
      output ctl_sda_o,
      output ctl_sda_oe,
      input sda
   );
endinterface

// file: verification/link_chk.sv
`timescale 1ns/10ps
module link_chk #(
   parameter int QUARTER_CYC = 4
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic scl,
   input wire logic sda,
   input wire logic ctl_sda_o,
   input wire logic ctl_sda_oe,
   input wire logic tgt_sda_o,
   input wire logic tgt_sda_oe
);
   localparam int PHASE_MIN = 2 * QUARTER_CYC;
   localparam int HOLD_MAX = 40 * QUARTER_CYC;
   logic scl_q_reg;
   logic sda_q_reg;
   logic start_seen_reg;
   logic [3:0] bit_cnt_reg;
   int low_cnt_reg;
   int high_cnt_reg;
   logic start_det;
   logic scl_rise;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   // start is sda falling while scl stays high
   assign start_det = scl && scl_q_reg && sda_q_reg && !sda;
   assign scl_rise = scl && !scl_q_reg;

   // delayed wire copies for edge detection
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl;
         sda_q_reg <= sda;
      end
   end

   // scl rises since start; saturates at 15 so it never wraps back into the address bits
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         start_seen_reg <= 1'b0;
         bit_cnt_reg <= 4'hf;
      end else if (start_det) begin
         start_seen_reg <= 1'b1;
         bit_cnt_reg <= 4'h0;
      end else if (scl_rise && bit_cnt_reg != 4'hf) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   // length of the current scl phase
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         low_cnt_reg <= 0;
         high_cnt_reg <= 0;
      end else begin
         low_cnt_reg <= scl ? 0 : low_cnt_reg + 1;
         high_cnt_reg <= scl ? high_cnt_reg + 1 : 0;
      end
   end

   chk_tgt_open_drain: assert property (
      tgt_sda_oe |-> !tgt_sda_o) else $error("target drives sda high");
   chk_ctl_open_drain: assert property (
      ctl_sda_oe |-> !ctl_sda_o) else $error("controller drives sda high");
   chk_tgt_stable_high: assert property (
      scl && scl_q_reg |-> $stable(tgt_sda_oe))
      else $error("target changed sda while scl high");
   chk_tgt_after_start: assert property (
      tgt_sda_oe |-> start_seen_reg) else $error("target drove before start");
   chk_addr_bits_free: assert property (
      scl_rise && bit_cnt_reg < 4'h8 |-> !tgt_sda_oe)
      else $error("target drove during address bits");
   chk_tgt_release_bound: assert property (
      $rose(tgt_sda_oe) |-> ##[1:HOLD_MAX] !tgt_sda_oe)
      else $error("target held sda too long");
   chk_scl_low_time: assert property (
      scl_rise |-> low_cnt_reg >= PHASE_MIN) else $error("scl low too short");
   chk_scl_high_time: assert property (
      !scl && scl_q_reg |-> high_cnt_reg >= PHASE_MIN)
      else $error("scl high too short");
endmodule

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
   localparam int QCYC = 4;
   localparam logic [1:0] STRAP = 2'h2;
   logic clk_in, arst_n_in, cmd_valid, cmd_ack, cmd_ready;
   logic rsp_valid, rsp_ack, wr_valid;
   i2c_ctrl_pkg::cmd_e cmd_op;
   logic [7:0] cmd_data, rsp_data, wr_addr, wr_data, wr_page, wr_book;
   logic [7:0] rbuf [2];
   logic [7:0] crc_exp, xor_exp, page, book;
   int miscompares;
   int checks_done;

   i2c_link_if link ();

   i2c_ctrl_controller #(.QUARTER_CYC(QCYC)) u_i2c_ctrl_controller (
      .bus(link.controller), .clk_in(clk_in), .arst_n_in(arst_n_in),
      .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_data_in(cmd_data),
      .cmd_ack_in(cmd_ack), .cmd_ready_out(cmd_ready),
      .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
      .rsp_ack_out(rsp_ack));

   i2c_ctrl_target u_i2c_ctrl_target (
      .bus(link.target), .clk_in(clk_in), .arst_n_in(arst_n_in),
      .adr_sel_in(STRAP), .wr_valid_out(wr_valid), .wr_addr_out(wr_addr),
      .wr_data_out(wr_data), .wr_page_out(wr_page), .wr_book_out(wr_book));

   link_chk #(.QUARTER_CYC(QCYC)) u_link_chk (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .scl(link.scl),
      .sda(link.sda), .ctl_sda_o(link.ctl_sda_o),
      .ctl_sda_oe(link.ctl_sda_oe), .tgt_sda_o(link.tgt_sda_o),
      .tgt_sda_oe(link.tgt_sda_oe));

   // 200 mhz system clock; scl is divided from it by the controller
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic final_report();
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
         miscompares++;
      end
   endtask

   // one controller command; waits are bounded so a hang ends the run
   task automatic cmd(input i2c_ctrl_pkg::cmd_e op, input logic [7:0] d,
                      input logic a);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 400) begin
         @(posedge clk_in);
         #1 n++;
      end
      if (n >= 400) begin
         miscompares++;
         final_report();
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_data = d;
      cmd_ack = a;
      @(posedge clk_in);
      #1 cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(posedge clk_in);
         #1 n++;
      end
      if (n >= 400) begin
         miscompares++;
         final_report();
      end
   endtask

   task automatic wbyte(input logic [7:0] d, input logic ack_exp);
      cmd(i2c_ctrl_pkg::CMD_WRITE, d, 1'b0);
      check({7'h00, rsp_ack}, {7'h00, ack_exp});
   endtask

   // msb-first crc, polynomial 07, no reflection
   function automatic logic [7:0] crc8(input logic [7:0] c, d);
      logic [7:0] v;
      v = c ^ d;
      for (int i = 0; i < 8; i++)
         v = v[7] ? ((v << 1) ^ i2c_ctrl_pkg::CRC_POLY) : (v << 1);
      return v;
   endfunction

   // bench copy of page, book and both checksums for one written byte
   task automatic model(input logic [7:0] a, input logic [7:0] d);
      if (page == 8'h00 && a == 8'h7e) crc_exp = d;
      else if (a != 8'h00 && !(page == 8'h00 && a == 8'h7f))
         crc_exp = crc8(crc_exp, d);
      if (book == 8'h8c && page == 8'h00 && a == 8'h7d) xor_exp = d;
      else if (book == 8'h8c && page != 8'h00 && a != 8'h00)
         xor_exp = xor_exp ^ d;
      if (page == 8'h00 && a == 8'h7f) book = d;
      if (a == 8'h00) page = d;
   endtask

   task automatic wr(input logic [7:0] r, d0, d1, input int n);
      logic [7:0] a;
      a = r;
      cmd(i2c_ctrl_pkg::CMD_START, 8'h00, 1'b0);
      wbyte({i2c_ctrl_pkg::ADDR_HIGH, STRAP, 1'b0}, 1'b1);
      wbyte(r, 1'b1);
      for (int i = 0; i < n; i++) begin
         wbyte((i == 0) ? d0 : d1, 1'b1);
         model(a, (i == 0) ? d0 : d1);
         a = a + 8'h01;
      end
      cmd(i2c_ctrl_pkg::CMD_STOP, 8'h00, 1'b0);
   endtask

   task automatic rd(input logic [7:0] r, input int n);
      cmd(i2c_ctrl_pkg::CMD_START, 8'h00, 1'b0);
      wbyte({i2c_ctrl_pkg::ADDR_HIGH, STRAP, 1'b0}, 1'b1);
      wbyte(r, 1'b1);
      cmd(i2c_ctrl_pkg::CMD_START, 8'h00, 1'b0);
      wbyte({i2c_ctrl_pkg::ADDR_HIGH, STRAP, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         cmd(i2c_ctrl_pkg::CMD_READ, 8'h00, i < n - 1);
         rbuf[i] = rsp_data;
      end
      cmd(i2c_ctrl_pkg::CMD_STOP, 8'h00, 1'b0);
   endtask

   // main sequence
   initial begin
      miscompares = 0;
      checks_done = 0;
      arst_n_in = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = i2c_ctrl_pkg::CMD_START;
      cmd_data = 8'h00;
      cmd_ack = 1'b0;
      crc_exp = 8'h00;
      xor_exp = 8'h00;
      page = 8'h00;
      book = 8'h00;
      repeat (5) @(posedge clk_in);
      #1 arst_n_in = 1'b1;
      rd(8'h00, 1); check(rbuf[0], i2c_ctrl_pkg::PAGE_RESET);
      rd(8'h7f, 1); check(rbuf[0], i2c_ctrl_pkg::BOOK_RESET);
      rd(8'h7e, 1); check(rbuf[0], i2c_ctrl_pkg::CRC_RESET);
      wr(8'h10, 8'h55, 8'h00, 1); check(wr_data, 8'h55);
      rd(8'h10, 1); check(rbuf[0], 8'h55);
      wr(8'h20, 8'ha1, 8'hb2, 2); check(wr_addr, 8'h21);
      rd(8'h20, 2); check(rbuf[0], 8'ha1);
      check(rbuf[1], 8'hb2);
      rd(8'h7e, 1); check(rbuf[0], crc_exp);
      rd(8'h7e, 1); check(rbuf[0], crc_exp);
      // foreign address: no ack, bytes after it dropped
      cmd(i2c_ctrl_pkg::CMD_START, 8'h00, 1'b0);
      wbyte({i2c_ctrl_pkg::ADDR_HIGH, ~STRAP, 1'b0}, 1'b0);
      cmd(i2c_ctrl_pkg::CMD_WRITE, 8'h10, 1'b0);
      cmd(i2c_ctrl_pkg::CMD_WRITE, 8'h99, 1'b0);
      cmd(i2c_ctrl_pkg::CMD_STOP, 8'h00, 1'b0);
      check(wr_data, 8'hb2);
      rd(8'h10, 1); check(rbuf[0], 8'h55);
      wr(8'h7e, 8'h3c, 8'h00, 1);
      rd(8'h7e, 1); check(rbuf[0], 8'h3c);
      wr(8'h7e, 8'h00, 8'h00, 1);
      rd(8'h7e, 1); check(rbuf[0], 8'h00);
      wr(8'h00, 8'h00, 8'h00, 1);
      wr(8'h7f, i2c_ctrl_pkg::BOOK_XOR, 8'h00, 1);
      rd(8'h7f, 1); check(rbuf[0], 8'h8c);
      rd(8'h7e, 1); check(rbuf[0], 8'h00);
      rd(8'h7d, 1); check(rbuf[0], i2c_ctrl_pkg::XOR_RESET);
      wr(8'h00, 8'h01, 8'h00, 1);
      rd(8'h00, 1); check(rbuf[0], 8'h01);
      wr(8'h40, 8'h5a, 8'h0f, 2); check(wr_page, 8'h01);
      wr(8'h00, 8'h00, 8'h00, 1);
      wr(8'h30, 8'h77, 8'h00, 1);
      rd(8'h7d, 1); check(rbuf[0], 8'h55);
      rd(8'h7e, 1); check(rbuf[0], crc_exp);
      wr(8'h7d, 8'h00, 8'h00, 1);
      rd(8'h7d, 1); check(rbuf[0], xor_exp);
      rd(8'h7e, 1); check(rbuf[0], crc_exp);
      wr(8'h7f, 8'haa, 8'h00, 1);
      wr(8'h00, 8'h01, 8'h00, 1);
      wr(8'h08, 8'h11, 8'h22, 5); check(wr_addr, 8'h0c);
      rd(8'h0b, 2); check(rbuf[0], 8'h22);
      check(rbuf[1], 8'h22);
      wr(8'h00, 8'h00, 8'h00, 1);
      rd(8'h7e, 1); check(rbuf[0], crc_exp);
      final_report();
   end
endmodule
